// *** design/fpt_ctrl.sv ***
// fan power modulation, tachometer measurement and AHB-Lite register slave
// assumes one 100 MHz clock, tach inputs synchronous to it, one AHB master
`timescale 1ns/10ps
`include "fpt_defines.svh"

// Summary of operation
// RULE1 - four independent fan power and tach channels
// RULE2 - power setting 0..100 sets switch duty
// RULE3 - modulation repeats at 18 Hz nominal
// RULE4 - tach averaged over 125 ms window
// RULE5 - fans measured in rotation, 125 ms each
// RULE6 - rpm from pulses-per-rev, raw count too
// RULE7 - reporting fan forced on at window start
// RULE8 - hold until glitch delay and two edges
// RULE9 - stretched pulse ends by 125 ms
// RULE10 - full or long pulses stay unchanged
// RULE11 - boot power, staggered start 0.5 s apart
// RULE12 - prescaled shared counter compared with duty
module fpt_ctrl #(
    parameter int PRESCALE = `FPT_PRESCALE,
    parameter int WIN_CYC = `FPT_WIN_CYC,
    parameter int GAP_CYC = `FPT_GAP_CYC,
    parameter logic [27:0] BOOT_POWER = {4{`FPT_FULL_POWER}}
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // fans
    input wire logic [3:0] fan_tach,
    output logic [3:0] fan_switch
);
    import fpt_pkg::*;

    fpt_state_t cur; // registered state
    fpt_state_t nxt; // next state

    // rpm from pulses in a 1/8 s window: hz = p*8, rpm = hz*60/ppr
    function automatic logic [23:0] fpt_rpm(input logic [15:0] p, input logic [1:0] code);
        logic [23:0] w;
        w = 24'(p);
        case (code)
            2'd0: fpt_rpm = 24'(w * 24'd480);
            2'd1: fpt_rpm = 24'(w * 24'd240);
            2'd2: fpt_rpm = 24'(w * 24'd160);
            default: fpt_rpm = 24'(w * 24'd120);
        endcase
    endfunction

    // clamp a written power byte to full scale
    function automatic logic [6:0] fpt_clamp(input logic [7:0] b);
        if (b > 8'h64) begin
            fpt_clamp = `FPT_FULL_POWER;
        end else begin
            fpt_clamp = b[6:0];
        end
    endfunction

    // next-state logic for every part of the block
    always_comb begin
        logic [3:0] pwm_on;
        logic [3:0] tach_rise;
        logic [3:0] tach_edge;
        logic win_last;
        logic [1:0] nidx;
        logic [15:0] fin_cnt; // pulse count including this cycle's edge
        pwm_on = '0;
        tach_rise = fan_tach & ~cur.tach_q;
        tach_edge = fan_tach ^ cur.tach_q;
        win_last = (cur.win == 32'(WIN_CYC - 1));
        nidx = cur.idx + 2'd1;
        // every window cycle counts, the last one too, so no edge is lost
        fin_cnt = cur.pulses;
        if (tach_rise[cur.idx] && cur.pulses != 16'hffff) begin
            fin_cnt = cur.pulses + 16'd1;
        end
        nxt = cur;
        nxt.tach_q = fan_tach;

        // shared period counter, advanced by a prescaler
        if (cur.prs == 16'(PRESCALE - 1)) begin // RULE12
            nxt.prs = '0;
            if (cur.step == 7'(`FPT_PWM_STEPS - 1)) begin // RULE3
                nxt.step = '0;
            end else begin
                nxt.step = cur.step + 7'd1;
            end
        end else begin
            nxt.prs = cur.prs + 16'd1;
        end

        // per-channel compare: on while counter is below the duty
        for (int i = 0; i < `FPT_NFAN; i++) begin // RULE1
            pwm_on[i] = (cur.step < cur.duty[i]); // RULE2 RULE12
        end

        // measurement window: one fan at a time, 125 ms each
        if (win_last) begin // RULE4
            nxt.win = '0;
            nxt.raw[cur.idx] = fin_cnt; // RULE6
            nxt.rpm[cur.idx] = fpt_rpm(fin_cnt, cur.ppr[cur.idx]); // RULE6
            nxt.force_on[cur.idx] = 1'b0; // RULE9
            nxt.idx = nidx; // RULE5
            nxt.pulses = '0;
        end else begin
            nxt.win = cur.win + 32'd1;
            nxt.pulses = fin_cnt;
        end

        // stretch: force on at window start for reporting fans
        if (cur.win == 32'd0) begin
            nxt.str_edges = '0;
            nxt.glt_cnt = cur.glitch;
            nxt.force_on[cur.idx] = cur.rep_en[cur.idx]; // RULE7
        end else if (!win_last && cur.force_on[cur.idx]) begin
            if (cur.glt_cnt != '0) begin
                nxt.glt_cnt = cur.glt_cnt - 24'd1;
            end
            if (tach_edge[cur.idx] && cur.str_edges != 2'd2) begin
                nxt.str_edges = cur.str_edges + 2'd1;
            end
            // release once the delay ran out and two edges were seen
            if (cur.glt_cnt == '0 && cur.str_edges == 2'd2) begin // RULE8
                nxt.force_on[cur.idx] = 1'b0;
            end
        end

        // power-up: release fans in order, a gap between fans that are on
        case (cur.phase)
            FPT_SEQ: begin
                if (cur.seq == 3'd4) begin
                    nxt.phase = FPT_RUN;
                end else if (cur.duty[cur.seq[1:0]] == '0) begin
                    // an off fan draws no current, so it takes no gap
                    nxt.rel[cur.seq[1:0]] = 1'b1;
                    nxt.seq = cur.seq + 3'd1;
                end else if (cur.seq_tmr == '0) begin // RULE11
                    nxt.rel[cur.seq[1:0]] = 1'b1;
                    nxt.seq = cur.seq + 3'd1;
                    nxt.seq_tmr = 32'(GAP_CYC - 1);
                end else begin
                    nxt.seq_tmr = cur.seq_tmr - 32'd1;
                end
            end
            FPT_RUN: begin
                nxt.rel = 4'hf;
            end
            default: begin
                nxt.phase = FPT_RUN;
            end
        endcase

        // switch drive: the override only adds on-time, never removes it
        nxt.fan_sw = cur.rel & (pwm_on | cur.force_on); // RULE10

        // ahb-lite: take the address phase, answer after one wait state
        nxt.ap_valid = 1'b0;
        nxt.ready = 1'b1;
        if (hsel && htrans[1] && hready) begin
            nxt.ap_valid = 1'b1;
            nxt.ap_write = hwrite;
            nxt.ap_addr = haddr[5:0];
            nxt.ready = 1'b0;
        end
        if (cur.ap_valid) begin
            nxt.rdata = '0;
            if (cur.ap_write) begin
                case (cur.ap_addr)
                    `FPT_REG_CTRL: begin
                        nxt.rep_en = hwdata[3:0];
                    end
                    `FPT_REG_POWER: begin
                        for (int i = 0; i < `FPT_NFAN; i++) begin
                            nxt.duty[i] = fpt_clamp(hwdata[8*i +: 8]); // RULE2
                        end
                    end
                    `FPT_REG_GLITCH: begin
                        nxt.glitch = hwdata[23:0];
                    end
                    `FPT_REG_PPR: begin
                        nxt.ppr = hwdata[7:0];
                    end
                    default: begin
                        // read-only or unmapped: write ignored
                    end
                endcase
            end else begin
                case (cur.ap_addr)
                    `FPT_REG_CTRL: nxt.rdata = {28'h0, cur.rep_en};
                    `FPT_REG_POWER: nxt.rdata = {1'b0, cur.duty[3], 1'b0, cur.duty[2],
                                                 1'b0, cur.duty[1], 1'b0, cur.duty[0]};
                    `FPT_REG_GLITCH: nxt.rdata = {8'h0, cur.glitch};
                    `FPT_REG_PPR: nxt.rdata = {24'h0, cur.ppr};
                    `FPT_REG_STATUS: nxt.rdata = {18'h0, cur.idx, cur.fan_sw, cur.force_on, cur.rel};
                    6'h20, 6'h24, 6'h28, 6'h2c: nxt.rdata = {16'h0, cur.raw[cur.ap_addr[3:2]]};
                    6'h30, 6'h34, 6'h38, 6'h3c: nxt.rdata = {8'h0, cur.rpm[cur.ap_addr[3:2]]};
                    default: nxt.rdata = '0;
                endcase
            end
        end
    end

    // one register bank for all state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur <= '0;
            cur.phase <= FPT_SEQ;
            cur.duty <= BOOT_POWER; // RULE11
            cur.rep_en <= `FPT_RST_REP_EN;
            cur.glitch <= `FPT_RST_GLITCH;
            cur.ppr <= `FPT_RST_PPR;
            cur.ready <= 1'b1;
            // tach lines idle on their pull-ups: avoids a false edge after reset
            cur.tach_q <= 4'hf;
        end else begin
            cur <= nxt;
        end
    end

    // outputs straight from flip-flops, hresp tied low
    assign hreadyout = cur.ready;
    assign hrdata = cur.rdata;
    assign hresp = 1'b0;
    assign fan_switch = cur.fan_sw;

endmodule

// *** design/fpt_defines.svh ***
// constants for the fan power and tachometer controller: offsets, fields, resets, timing
// assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus
`ifndef FPT_DEFINES_SVH
`define FPT_DEFINES_SVH

// register byte offsets
`define FPT_REG_CTRL 6'h00
`define FPT_REG_POWER 6'h04
`define FPT_REG_GLITCH 6'h08
`define FPT_REG_PPR 6'h0c
`define FPT_REG_STATUS 6'h10
`define FPT_REG_RAW0 6'h20
`define FPT_REG_RPM0 6'h30

// field sizes
`define FPT_NFAN 4
`define FPT_DUTY_W 7
`define FPT_RAW_W 16
`define FPT_RPM_W 24
`define FPT_GLT_W 24

// reset values
`define FPT_RST_REP_EN 4'h0
`define FPT_RST_GLITCH 24'h000000
`define FPT_RST_PPR 8'h55
`define FPT_FULL_POWER 7'h64

// timing
`define FPT_CLK_HZ 100000000
`define FPT_PWM_HZ 18
`define FPT_PWM_STEPS 100
`define FPT_WIN_MS 125
`define FPT_GAP_MS 500
`define FPT_PRESCALE (`FPT_CLK_HZ / (`FPT_PWM_HZ * `FPT_PWM_STEPS))
`define FPT_WIN_CYC ((`FPT_CLK_HZ / 1000) * `FPT_WIN_MS)
`define FPT_GAP_CYC ((`FPT_CLK_HZ / 1000) * `FPT_GAP_MS)

`endif

// *** design/fpt_pkg.sv ***
// types for the fan power and tachometer controller
// assumes fpt_defines.svh is on the include path
`include "fpt_defines.svh"

package fpt_pkg;

    // power-up phase, one-hot
    typedef enum logic [1:0] {
        FPT_SEQ = 2'b01,
        FPT_RUN = 2'b10
    } fpt_phase_t;

    // whole state of the controller
    typedef struct packed {
        fpt_phase_t phase;
        logic [15:0] prs;
        logic [6:0] step;
        logic [3:0][6:0] duty;
        logic [3:0] rep_en;
        logic [3:0][1:0] ppr;
        logic [23:0] glitch;
        logic [3:0][15:0] raw;
        logic [3:0][23:0] rpm;
        logic [1:0] idx;
        logic [31:0] win;
        logic [15:0] pulses;
        logic [1:0] str_edges;
        logic [23:0] glt_cnt;
        logic [3:0] force_on;
        logic [3:0] tach_q;
        logic [3:0] rel;
        logic [2:0] seq;
        logic [31:0] seq_tmr;
        logic [3:0] fan_sw;
        logic ap_valid;
        logic ap_write;
        logic [5:0] ap_addr;
        logic ready;
        logic [31:0] rdata;
    } fpt_state_t;

endpackage

// *** verif/fpt_checker.sv ***
// checker: bus handshake and read data relations of the fan controller
// bound to fpt_ctrl, sees its ports only
`timescale 1ns/10ps
module fpt_checker (
    // clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // fan drive
    input wire logic [3:0] fan_switch
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // transfer accepted at this edge
    wire logic take = hsel && htrans[1] && hready;
    a_one_wait: assert property (take |=> !hreadyout ##1 hreadyout) else $error("bad wait");
    a_no_stray: assert property ($fell(hreadyout) |-> $past(take)) else $error("stray wait");
    a_ready_back: assert property ($rose(hreadyout) |-> $past(take, 2)) else $error("late ready");
    a_okay_resp: assert property (hresp == 1'b0) else $error("bad resp");
    // read data only moves when a transfer completes
    a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata)) else $error("rdata moved");
    a_write_zero: assert property (take && hwrite |=> ##1 hrdata == 32'h0) else $error("rdata on write");
    a_hole_zero: assert property (take && !hwrite && haddr[5:0] == 6'h14 |=> ##1 hrdata == 32'h0) else $error("hole");
    a_ctrl_pad: assert property (take && !hwrite && haddr[5:0] == 6'h00 |=> ##1 hrdata[31:4] == 28'h0) else $error("pad");
    c_write: cover property (take && hwrite);
    c_read: cover property (take && !hwrite);
    c_fan_on: cover property ($rose(fan_switch[0]));
endmodule
bind fpt_ctrl fpt_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fan_switch(fan_switch));

// *** verif/fpt_fan_model.sv ***
// three-wire fan: tach toggles every half period while powered
// tach rests on its pull-up when unpowered or stalled
`timescale 1ns/10ps
module fpt_fan_model #(
    parameter int HALF = 5
) (
    // clock
    input wire logic hclk,
    // drive and fault control
    input wire logic powered,
    input wire logic stall,
    // tach line
    output logic tach = 1'b1
);
    int cnt = 0; // cycles since last toggle
    // a stopped rotor gives no edges, so restart the count
    always @(posedge hclk) begin
        if (!powered || stall) begin
            tach <= 1'b1;
            cnt <= 0;
        end else if (cnt == HALF - 1) begin
            tach <= !tach;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// *** verif/tb_fpt_ctrl.sv ***
// bench: drives the fan controller over AHB-Lite, checks drive and speed results
// assumes the fan model and bound checker are compiled alongside
`timescale 1ns/10ps
module tb_fpt_ctrl;
    import fpt_pkg::*;
    localparam int WIN = 200; // shortened window
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0] htrans = 2'h0, idx;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [3:0] fan_switch, stall = 4'h0;
    wire logic [3:0] fan_tach;
    int cnt [4];
    int bad_count = 0, checks = 0;
    // half periods that divide the window, so edge counts are exact
    function automatic int half(input int i);
        return (i == 3) ? 25 : (5 << i);
    endfunction
    fpt_ctrl #(.PRESCALE(2), .WIN_CYC(WIN), .GAP_CYC(50)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fan_tach(fan_tach), .fan_switch(fan_switch));
    for (genvar i = 0; i < 4; i++) begin : g_fan
        fpt_fan_model #(.HALF(half(i))) fan_u (.hclk(hclk), .powered(fan_switch[i]), .stall(stall[i]),
            .tach(fan_tach[i]));
    end
    initial begin
        forever #5 hclk = ~hclk;
    end
    // one single transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {26'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // range compare; an unknown never passes
    task automatic check(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            bad_count++;
            $display("Error %0t got %h want %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic check_rd(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp, exp);
    endtask
    // on-cycles of each switch over n edges
    task automatic count_on(input int n);
        cnt = '{default: 0};
        repeat (n) begin
            @(posedge hclk);
            for (int i = 0; i < 4; i++) cnt[i] += (fan_switch[i] === 1'b1);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge hclk);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        check_rd(6'h00, 32'h0);
        check_rd(6'h04, 32'h64646464);
        check_rd(6'h08, 32'h0);
        check_rd(6'h0c, 32'h55);
        bus(1'b1, 6'h14, 32'hffffffff);
        check_rd(6'h14, 32'h0);
        // fans released one gap apart
        for (int k = 1; k < 4; k++) begin
            repeat (k == 1 ? 48 : (k == 2 ? 60 : 20)) @(posedge hclk);
            bus(1'b0, 6'h10, 32'h0);
            check(rd & 32'hf, (32'h1 << (k + 1)) - 1, (32'h1 << (k + 1)) - 1);
        end
        $display("startup test done");
        bus(1'b1, 6'h04, 32'h96641900);
        repeat (WIN) @(posedge hclk);
        count_on(WIN);
        check(cnt[0], 0, 0);
        check(cnt[1], 50, 50);
        check(cnt[2], 200, 200);
        check(cnt[3], 200, 200);
        $display("duty test done");
        bus(1'b1, 6'h04, 32'h64646464);
        bus(1'b1, 6'h0c, 32'he4);
        repeat (8 * WIN) @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            check_rd(6'h20 + 6'(4 * i), 32'(WIN / (2 * half(i))));
            check_rd(6'h30 + 6'(4 * i), 32'(WIN / (2 * half(i)) * 480 / (i + 1)));
        end
        bus(1'b0, 6'h10, 32'h0);
        idx = rd[13:12] + 2'h1;
        repeat (WIN - 4) @(posedge hclk);
        bus(1'b0, 6'h10, 32'h0);
        check(rd[13:12], idx, idx);
        $display("speed test done");
        bus(1'b1, 6'h04, 32'h00006400);
        bus(1'b1, 6'h00, 32'h3);
        // no glitch delay, long glitch delay, stalled fan
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, 6'h08, k == 1 ? 32'd150 : 32'd0);
            stall[0] <= (k == 2);
            do @(posedge hclk); while (fan_switch[0] !== 1'b1);
            count_on(3 * WIN);
            check(cnt[0], k == 0 ? 1 : (k == 1 ? 145 : WIN - 10), k == 0 ? 20 : (k == 1 ? 160 : WIN));
            check(cnt[1], 3 * WIN, 3 * WIN);
        end
        $display("stretch test done");
        wrap_up();
    end
endmodule
